// [src/tzx_pkg.sv]
package tzx_pkg;
  localparam logic [6:0] OP_TEST_ZERO_SKIP = 7'h33;
  localparam logic [7:0] OP_XOR_LITERAL = 8'h0a;
  localparam logic [5:0] OP_XOR_REGISTER = 6'h06;
  localparam int TSTZ_MSB = 15;
  localparam int TSTZ_LSB = 9;
  localparam int XORL_LSB = 8;
  localparam int XORW_LSB = 10;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [3:0] BANK_ACCESS = 4'h0;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  typedef enum logic [3:0] {
    TZX_Q1 = 4'b0001,
    TZX_Q2 = 4'b0010,
    TZX_Q3 = 4'b0100,
    TZX_Q4 = 4'b1000
  } tzx_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic we;
  } tzx_file_wr_t;
endpackage

// [src/tzx_exec.sv]
`timescale 1ns/1ps
`default_nettype none
module tzx_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic nextIsTwoWord,
  input wire logic [3:0] bank_select_register,
  output logic [11:0] fileRdAddr,
  input wire logic [7:0] fileRdData,
  output tzx_pkg::tzx_file_wr_t fileWr,
  output logic [7:0] workReg,
  output logic flagNegative,
  output logic flagZero,
  output tzx_pkg::tzx_phase_t phase,
  output logic flushActive,
  output logic cycleEnd
);
  logic [15:0] instr;
  logic [7:0] operand;
  logic [7:0] result;
  logic [1:0] flushLeft;
  logic isTest;
  logic isXorL;
  logic isXorW;
  logic [11:0] decAddr;
  logic [7:0] xorOut;
  logic skipTaken;
  tzx_pkg::tzx_phase_t next_phase;

  // Decode uses the latched word so mid-cycle changes on instrWord are harmless
  assign isTest = !flushActive &&
    instr[tzx_pkg::TSTZ_MSB:tzx_pkg::TSTZ_LSB] == tzx_pkg::OP_TEST_ZERO_SKIP;
  assign isXorL = !flushActive &&
    instr[15:tzx_pkg::XORL_LSB] == tzx_pkg::OP_XOR_LITERAL;
  assign isXorW = !flushActive &&
    instr[15:tzx_pkg::XORW_LSB] == tzx_pkg::OP_XOR_REGISTER;
  assign decAddr = {(instr[tzx_pkg::BANK_BIT] ? bank_select_register
                    : tzx_pkg::BANK_ACCESS), instr[7:0]};
  assign xorOut = isXorL ? (workReg ^ instr[7:0]) : (workReg ^ operand);
  assign skipTaken = isTest && operand == 8'h00;
  assign cycleEnd = phase == tzx_pkg::TZX_Q4;

  always_comb begin
    case (phase)
      tzx_pkg::TZX_Q1: next_phase = tzx_pkg::TZX_Q2;
      tzx_pkg::TZX_Q2: next_phase = tzx_pkg::TZX_Q3;
      tzx_pkg::TZX_Q3: next_phase = tzx_pkg::TZX_Q4;
      tzx_pkg::TZX_Q4: next_phase = tzx_pkg::TZX_Q1;
      default: next_phase = tzx_pkg::TZX_Q1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= tzx_pkg::TZX_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Q1 latch: instruction captured only at cycle start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      instr <= 16'h0000;
      fileRdAddr <= 12'h000;
    end else if (phase == tzx_pkg::TZX_Q1) begin
      instr <= instrValid ? instrWord : 16'h0000;
    end else if (phase == tzx_pkg::TZX_Q2) begin
      fileRdAddr <= decAddr;
    end
  end

  // Operand sampled in Q3 since the address settles at Q2 end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      operand <= 8'h00;
      result <= 8'h00;
    end else if (phase == tzx_pkg::TZX_Q3) begin
      operand <= fileRdData;
    end else if (phase == tzx_pkg::TZX_Q4) begin
      result <= xorOut;
    end
  end

  // Result only leaves the block in Q4
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      workReg <= tzx_pkg::WORK_RESET;
      flagNegative <= 1'b0;
      flagZero <= 1'b0;
      fileWr <= '0;
    end else begin
      fileWr.we <= 1'b0;
      if (phase == tzx_pkg::TZX_Q4 && (isXorL || isXorW)) begin
        flagNegative <= xorOut[7];
        flagZero <= xorOut == 8'h00;
        if (isXorL || !instr[tzx_pkg::DEST_BIT]) begin
          workReg <= xorOut;
        end else begin
          fileWr <= '{addr: fileRdAddr, data: xorOut, we: 1'b1};
        end
      end
    end
  end

  // Flush count decided at the last phase of the test cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flushLeft <= 2'h0;
      flushActive <= 1'b0;
    end else if (phase == tzx_pkg::TZX_Q4) begin
      if (skipTaken) begin
        flushActive <= 1'b1;
        flushLeft <= nextIsTwoWord ? 2'h1 : 2'h0;
      end else if (flushLeft != 2'h0) begin
        flushLeft <= flushLeft - 2'h1;
      end else begin
        flushActive <= 1'b0;
      end
    end
  end

  a_skip_flush: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && skipTaken |=> flushActive [*4])
    else $error("skip did not flush");
  a_two_word_flush: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && skipTaken && nextIsTwoWord |=> flushActive [*8])
    else $error("second flush missing");
  a_no_skip: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isTest && operand != 8'h00 |=> !flushActive)
    else $error("nonzero skipped");
  a_flush_idle: assert property (@(posedge sys_clk) disable iff (rst)
    flushActive |=> !fileWr.we && $stable(workReg))
    else $error("flush cycle active");
  a_decode_test: assert property (@(posedge sys_clk) disable iff (rst)
    isTest |-> instr[15:9] == 7'h33)
    else $error("bad test decode");
  a_bank_access: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q2 && !instr[8] |=> fileRdAddr[11:8] == 4'h0)
    else $error("access bank not used");
  a_xorl_result: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorL |=> workReg == ($past(workReg) ^ $past(instr[7:0])))
    else $error("literal xor wrong");
  a_test_flags: assert property (@(posedge sys_clk) disable iff (rst)
    isTest |=> $stable(flagZero) && $stable(flagNegative))
    else $error("test changed flags");
  a_xorw_file: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorW && instr[9] |=> fileWr.we && $stable(workReg))
    else $error("file write missing");
  a_write_phase: assert property (@(posedge sys_clk) disable iff (rst)
    fileWr.we |-> $past(phase) == tzx_pkg::TZX_Q4)
    else $error("write outside Q4");
  // Phase ring must never stall, or every instruction would stretch
  a_phase_start: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q1 |=> phase == tzx_pkg::TZX_Q2)
    else $error("phase ring stalled");
  a_phase_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 |=> phase == tzx_pkg::TZX_Q1)
    else $error("phase ring did not wrap");
  a_addr_hold: assert property (@(posedge sys_clk) disable iff (rst)
    phase != tzx_pkg::TZX_Q2 |=> $stable(fileRdAddr))
    else $error("read address moved outside Q2");
  a_bank_select: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q2 && instr[tzx_pkg::BANK_BIT] |=>
    fileRdAddr[11:8] == $past(bank_select_register))
    else $error("bank select not used");
  // Flush length counts whole instruction cycles, four phases each
  a_one_word_end: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && skipTaken && !nextIsTwoWord |=>
    flushActive [*4] ##1 !flushActive)
    else $error("single flush wrong length");
  a_two_word_end: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && skipTaken && nextIsTwoWord |=>
    flushActive [*8] ##1 !flushActive)
    else $error("double flush wrong length");
  a_flush_blank: assert property (@(posedge sys_clk) disable iff (rst)
    flushActive |-> !isTest && !isXorL && !isXorW)
    else $error("flushed word decoded");
  a_flush_flags: assert property (@(posedge sys_clk) disable iff (rst)
    flushActive |=> $stable(flagZero) && $stable(flagNegative))
    else $error("flush changed flags");
  a_test_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isTest |=> !fileWr.we && $stable(workReg))
    else $error("test wrote a result");
  // Expected values rebuilt from operands, not from the shared xor path
  a_xorl_flags: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorL |=>
    flagNegative == $past(workReg[7] ^ instr[7]) &&
    flagZero == ($past(workReg ^ instr[7:0]) == 8'h00))
    else $error("literal xor flags wrong");
  a_xorl_no_write: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorL |=> !fileWr.we)
    else $error("literal xor wrote file");
  a_xorw_work: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorW && !instr[tzx_pkg::DEST_BIT] |=>
    !fileWr.we && workReg == ($past(workReg) ^ $past(operand)))
    else $error("register xor to work wrong");
  a_xorw_data: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorW && instr[tzx_pkg::DEST_BIT] |=>
    fileWr.data == ($past(workReg) ^ $past(operand)) &&
    fileWr.addr == $past(fileRdAddr))
    else $error("register xor write wrong");
  a_xorw_flags: assert property (@(posedge sys_clk) disable iff (rst)
    phase == tzx_pkg::TZX_Q4 && isXorW |=>
    flagZero == (($past(workReg) ^ $past(operand)) == 8'h00) &&
    flagNegative == $past(workReg[7] ^ operand[7]))
    else $error("register xor flags wrong");
  a_write_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    fileWr.we |=> !fileWr.we)
    else $error("write strobe held");

  c_skip: cover property (@(posedge sys_clk) phase == tzx_pkg::TZX_Q4 && skipTaken);
  c_skip_two: cover property (@(posedge sys_clk) skipTaken && nextIsTwoWord && cycleEnd);
  c_xorl: cover property (@(posedge sys_clk) isXorL && cycleEnd);
  c_xorw_file: cover property (@(posedge sys_clk) fileWr.we);
  c_no_skip: cover property (@(posedge sys_clk) isTest && operand != 8'h00 && cycleEnd);
endmodule
`default_nettype wire

// [dv/test_skip_and_xor_execution_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module test_skip_and_xor_execution_bench;
  typedef struct packed {
    logic rdChk;
    logic [11:0] rd;
    logic [7:0] w;
    logic n, z, fl;
    tzx_pkg::tzx_file_wr_t wr;
  } tzx_exp_t;
  logic sysClk = 0, rst = 1, instrValid = 0, nextIsTwoWord = 0;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0] bankSel = 4'h0, eb;
  logic [11:0] rdAddr;
  logic [7:0] work, wExp = 8'h00, f, opnd, res;
  logic flagN, flagZ, flushOn, nExp = 0, zExp = 0, a, d, cycEnd;
  logic [1:0] sel;
  tzx_pkg::tzx_file_wr_t fileWr;
  tzx_pkg::tzx_phase_t phase;
  logic [31:0] lfsr = 32'hffcaeb44;
  tzx_exp_t expQ[$];
  tzx_exp_t e, g;
  int err_total = 0, num_checks = 0, flushLeft = 0, sinceQ1 = -100;
  // Operand depends on bank so a wrong bank gives wrong data
  wire logic [7:0] rdData = rdAddr[7:0] ^ {rdAddr[11:8], rdAddr[11:8]};
  tzx_exec i_dut (.sys_clk(sysClk), .rst(rst), .instrWord(instrWord),
    .instrValid(instrValid), .nextIsTwoWord(nextIsTwoWord),
    .bank_select_register(bankSel), .fileRdAddr(rdAddr), .fileRdData(rdData),
    .fileWr(fileWr), .workReg(work), .flagNegative(flagN), .flagZero(flagZ),
    .phase(phase), .flushActive(flushOn), .cycleEnd(cycEnd));
  always #2.5 sysClk = ~sysClk;
  function automatic logic [31:0] nextRnd(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic compare(logic [20:0] got, logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    // Results never seen count against the run
    if (expQ.size() != 0) err_total++;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Half-ns offset keeps each check ahead of the next drive
  initial forever begin
    @(posedge sysClk);
    #0.5;
    sinceQ1++;
    if (sinceQ1 == 3) compare({20'h0, cycEnd}, 21'h1);
    if (phase === tzx_pkg::TZX_Q1 && expQ.size() > 0) begin
      sinceQ1 = 0;
      g = expQ.pop_front();
      compare({20'h0, cycEnd}, 21'h0);
      compare({11'h0, flagN, flagZ, work}, {11'h0, g.n, g.z, g.w});
      compare(g.wr.we ? fileWr : {20'h0, fileWr.we}, g.wr);
      compare({20'h0, flushOn}, {20'h0, g.fl});
      if (g.rdChk) compare({9'h0, rdAddr}, {9'h0, g.rd});
    end
  end
  initial begin
    repeat (10) @(posedge sysClk);
    #1 rst = 0;
    for (int k = 0; k < 400; k++) begin
      lfsr = nextRnd(lfsr);
      {d, a, sel} = lfsr[3:0];
      bankSel = lfsr[7:4];
      f = lfsr[15:8];
      eb = a ? bankSel : tzx_pkg::BANK_ACCESS;
      if (sel == 2'd2 && lfsr[16]) f = {eb, eb};
      opnd = f ^ {eb, eb};
      instrValid = lfsr[19:17] != 3'h0;
      nextIsTwoWord = lfsr[20];
      case (sel)
        2'd0: instrWord = {tzx_pkg::OP_XOR_LITERAL, f};
        2'd1: instrWord = {tzx_pkg::OP_XOR_REGISTER, d, a, f};
        2'd2: instrWord = {tzx_pkg::OP_TEST_ZERO_SKIP, a, f};
        default: instrWord = {8'hff, f};
      endcase
      e = '0;
      if (flushLeft > 0) flushLeft--;
      else if (instrValid) begin
        res = (sel == 2'd0) ? wExp ^ f : wExp ^ opnd;
        if (sel < 2'd2) begin
          nExp = res[7];
          zExp = res == 8'h00;
          if (sel == 2'd1 && d) e.wr = {eb, f, res, 1'b1};
          else wExp = res;
        end
        if (sel == 2'd1 || sel == 2'd2) e.rd = {eb, f};
        e.rdChk = sel == 2'd1 || sel == 2'd2;
        if (sel == 2'd2 && opnd == 8'h00) flushLeft = nextIsTwoWord ? 2 : 1;
      end
      e.w = wExp;
      e.n = nExp;
      e.z = zExp;
      e.fl = flushLeft > 0;
      expQ.push_back(e);
      repeat (4) @(posedge sysClk);
      #1;
    end
    end_of_test;
  end
  initial begin
    #20000;
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
